// [core/coproc_translation_io_pkg.sv]
// Constants and types shared by the coprocessor translation and I/O block
package coproc_translation_io_pkg;

  // ****************************************************************
  // Transfer kinds and register numbers
  // ****************************************************************
  localparam logic [1:0] OP_FROM_MEM = 2'h0;  // Coprocessor load
  localparam logic [1:0] OP_TO_MEM = 2'h1;    // Coprocessor store
  localparam logic [1:0] OP_FROM_CPU = 2'h2;  // CPU register to coproc
  localparam logic [1:0] OP_TO_CPU = 2'h3;    // Coproc to CPU register

  localparam logic [2:0] REG_OWN_GROUP = 3'h7;  // Numbers 56 to 63
  localparam logic [5:0] REG_TAG = 6'h38;
  localparam logic [5:0] REG_PAGE = 6'h39;
  localparam logic [5:0] REG_CTL = 6'h3a;
  localparam logic [5:0] REG_FAULT = 6'h3b;
  localparam logic [5:0] REG_PSW = 6'h3c;
  localparam logic [5:0] REG_LOCK = 6'h3d;
  localparam logic [5:0] REG_REMOTE = 6'h3e;

  // ****************************************************************
  // Translation buffer geometry and field positions
  // ****************************************************************
  localparam int unsigned ROW_W = 7;
  localparam int unsigned SETS = 4;
  localparam int unsigned PID_W = 8;
  localparam int unsigned HIGH_W = 9;
  localparam int unsigned PAGE_W = 16;
  localparam int unsigned TAG_BITS = 19;  // pid, high page, valid, writable

  localparam int unsigned VA_SEL_LSB = 23;   // Set selects s0..s3
  localparam int unsigned VA_ROW_LSB = 16;   // Row / low page bits
  localparam int unsigned VA_HIGH_LSB = 23;  // High page bits
  localparam int unsigned TAG_PID_LSB = 24;
  localparam int unsigned TAG_HIGH_LSB = 15;
  localparam int unsigned TAG_VALID_BIT = 1;
  localparam int unsigned TAG_WRITE_BIT = 0;
  localparam int unsigned PAGE_LSB = 16;     // Real page in upper half

  localparam logic [31:0] TAG_MASK = 32'hffff_8003;
  localparam logic [31:0] TAG_RESET = 32'h0000_0000;
  localparam logic [15:0] PAGE_RESET = 16'h0000;

  // ****************************************************************
  // Peripheral control word layout
  // ****************************************************************
  localparam int unsigned CTL_SETCTL_BIT = 31;
  localparam int unsigned CTL_READ_BIT = 30;
  localparam int unsigned CTL_WRITE_BIT = 29;
  localparam int unsigned MCREG_LSB = 0;
  localparam int unsigned MCREG_W = 4;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [3:0] MCREG_RESET = 4'h0;

  // Operation handed to the memory controller
  typedef enum logic [2:0] {
    IO_NONE,
    IO_READ,
    IO_WRITE,
    IO_SETCTL,
    IO_GETCTL
  } io_kind_type;

endpackage

// [core/coproc_translation_io_regs.sv]
// Coprocessor register decode, translation buffer access and I/O control
//
// Notes on behaviour
// R1 - Own numbers 56 to 63 only
// R2 - Only data transfers; no coprocessor arithmetic
// R3 - Privileged transfers in user mode fault
// R4 - Numbers 56..62 map to listed operations
// R5 - Tag holds pid, high page, valid, writable
// R6 - Tag holding loads from and returns to CPU
// R7 - Entry address: select bits s3..s0, row
// R8 - Row combined with process identity
// R9 - Index is low page xor low pid
// R10 - Tag fetch reads one selected set
// R11 - Tag store writes every selected set
// R12 - Page word: real page in upper half
// R13 - Page holding moves to and from CPU
// R14 - Page fetch reads one selected set
// R15 - Page store writes every selected set
// R16 - Control word write-only, kernel only
// R17 - Control word load has no side effect
// R18 - Start uses fetched word as data
// R19 - Software sets exactly one operation select
// R20 - Read sends word as device address
// R21 - Write sends address with write value
// R22 - Set-control uses previously latched register number
// R23 - Addresses pass normal translation
// R24 - Undefined bits ignored, read as zero
// R25 - Register number latched at each issue
module coproc_translation_io_regs
  import coproc_translation_io_pkg::*;
#(
  parameter int unsigned ROWS = 128
) (
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Coprocessor transfer from the CPU pipeline
  input wire logic cop_valid,
  input wire logic [1:0] cop_op,
  input wire logic [5:0] cop_reg,
  input wire logic user_mode,
  input wire logic [31:0] cop_cpu_word,
  input wire logic [31:0] cop_vaddr,
  input wire logic [31:0] cop_mem_word,
  input wire logic [PID_W-1:0] cur_pid,
  // Answer to the CPU pipeline
  output logic [31:0] cpu_word_q,
  output logic cpu_word_valid_q,
  output logic priv_fault_q,
  // Request to the memory controller
  output logic mc_req_q,
  output io_kind_type mc_kind_q,
  output logic [31:0] mc_word_q,
  output logic [MCREG_W-1:0] mc_reg_q,
  // Normal translation lookup
  input wire logic lk_valid,
  input wire logic [31:0] lk_vaddr,
  input wire logic lk_store,
  input wire logic lk_kernel,
  output logic lk_done_q,
  output logic [PAGE_W-1:0] lk_page_q,
  output logic lk_tb_fault_q,
  output logic lk_wp_fault_q
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Buffer row from low page bits and process identity
  function automatic logic [ROW_W-1:0] tb_index(
    input logic [ROW_W-1:0] low, input logic [PID_W-1:0] pid);
    tb_index = low ^ pid[ROW_W-1:0];
  endfunction

  // Flat entry number of one set at one row
  function automatic logic [ROW_W+1:0] entry_at(
    input logic [ROW_W-1:0] row, input int unsigned s);
    entry_at = {row, s[1:0]};
  endfunction

  // Lowest selected set; software promises exactly one on fetches
  function automatic logic [1:0] first_set(input logic [SETS-1:0] sel);
    first_set = 2'h0;
    for (int s = SETS - 1; s >= 0; s--) begin
      if (sel[s]) begin
        first_set = s[1:0];
      end
    end
  endfunction

  // Stored tag fields rebuilt as a register word, unused bits zero
  function automatic logic [31:0] tag_word(input logic [TAG_BITS-1:0] t);
    tag_word = 32'h0000_0000;
    tag_word[TAG_PID_LSB +: PID_W] = t[TAG_BITS-1 -: PID_W];
    tag_word[TAG_HIGH_LSB +: HIGH_W] = t[2 +: HIGH_W];
    tag_word[TAG_VALID_BIT] = t[1];
    tag_word[TAG_WRITE_BIT] = t[0];
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [TAG_BITS-1:0] tag_mem [ROWS*SETS];
  logic [PAGE_W-1:0] page_mem [ROWS*SETS];

  logic [31:0] translation_tag_holding_q;
  logic [PAGE_W-1:0] translation_data_holding_q;
  logic [31:0] peripheral_control_word_q;
  logic [MCREG_W-1:0] mcreg_prev_q;

  // ****************************************************************
  // Transfer decode
  // ****************************************************************
  // Only 56..63 are ours; the rest belong to the other coprocessor
  wire own = cop_valid && (cop_reg[5:3] == REG_OWN_GROUP);  // R1
  // Arithmetic forms never arrive on this port; only transfers decode
  wire is_tag = own && (cop_reg == REG_TAG);  // R2 R4
  wire is_page = own && (cop_reg == REG_PAGE);  // R4
  wire is_ctl = own && (cop_reg == REG_CTL);  // R4
  wire is_pl = own && (cop_reg == REG_PSW || cop_reg == REG_LOCK);
  wire to_cpu = (cop_op == OP_TO_CPU);
  wire from_cpu = (cop_op == OP_FROM_CPU);
  wire from_mem = (cop_op == OP_FROM_MEM);
  wire to_mem = (cop_op == OP_TO_MEM);

  // Reading holdings back stays open to user mode
  wire priv_op = ((is_tag || is_page || is_ctl) && !to_cpu)
    || (is_pl && from_cpu);  // R3
  wire fault = user_mode && priv_op;  // R3
  wire go = own && !fault;

  wire tag_from_cpu = go && is_tag && from_cpu;
  wire tag_fetch = go && is_tag && from_mem;
  wire tag_store = go && is_tag && to_mem;
  wire tag_to_cpu = go && is_tag && to_cpu;
  wire page_from_cpu = go && is_page && from_cpu;
  wire page_fetch = go && is_page && from_mem;
  wire page_store = go && is_page && to_mem;
  wire page_to_cpu = go && is_page && to_cpu;
  wire ctl_load = go && is_ctl && from_cpu;  // R16
  wire io_start = go && is_ctl && from_mem;
  wire io_get = go && is_ctl && to_mem;

  // ****************************************************************
  // Entry addressing
  // ****************************************************************
  // Select bits and row from the transfer address
  wire [SETS-1:0] sel = cop_vaddr[VA_SEL_LSB +: SETS];  // R7
  wire [ROW_W-1:0] row = cop_vaddr[VA_ROW_LSB +: ROW_W];  // R7
  wire [ROW_W-1:0] ent_row = tb_index(row, cur_pid);  // R8
  wire [ROW_W+1:0] ent_rd = entry_at(ent_row, first_set(sel));
  wire [31:0] tag_rd_word = tag_word(tag_mem[ent_rd]);  // R10
  wire [PAGE_W-1:0] page_rd = page_mem[ent_rd];  // R14

  // Holding tag packed for the buffer
  wire [TAG_BITS-1:0] tag_packed = {
    translation_tag_holding_q[TAG_PID_LSB +: PID_W],
    translation_tag_holding_q[TAG_HIGH_LSB +: HIGH_W],
    translation_tag_holding_q[TAG_VALID_BIT],
    translation_tag_holding_q[TAG_WRITE_BIT]};  // R5

  // ****************************************************************
  // Memory controller decode
  // ****************************************************************
  wire [2:0] ctl_ops = {
    peripheral_control_word_q[CTL_SETCTL_BIT],
    peripheral_control_word_q[CTL_READ_BIT],
    peripheral_control_word_q[CTL_WRITE_BIT]};
  wire [MCREG_W-1:0] ctl_mcreg =
    peripheral_control_word_q[MCREG_LSB +: MCREG_W];

  // More than one select set is undefined; it is simply not issued
  io_kind_type start_kind;
  always_comb begin
    case (ctl_ops)
      3'h4: start_kind = IO_SETCTL;
      3'h2: start_kind = IO_READ;  // R20
      3'h1: start_kind = IO_WRITE;  // R21
      default: start_kind = IO_NONE;
    endcase
  end
  wire io_issue = io_start || io_get;  // R25
  wire start_ok = io_start && (start_kind != IO_NONE);

  // ****************************************************************
  // Normal translation lookup
  // ****************************************************************
  wire [PAGE_W-1:0] lk_vpage = lk_vaddr[VA_ROW_LSB +: PAGE_W];
  wire [ROW_W-1:0] lk_row = tb_index(lk_vpage[ROW_W-1:0], cur_pid);  // R9
  wire [HIGH_W-1:0] lk_high = lk_vaddr[VA_HIGH_LSB +: HIGH_W];

  // Two matching sets are undefined; the lowest one wins here
  logic lk_hit;
  logic lk_wr_ok;
  logic [PAGE_W-1:0] lk_real;
  always_comb begin
    logic [TAG_BITS-1:0] t;
    t = '0;
    lk_hit = 1'b0;
    lk_wr_ok = 1'b0;
    lk_real = PAGE_RESET;
    for (int s = SETS - 1; s >= 0; s--) begin
      t = tag_mem[entry_at(lk_row, s)];
      if (t[1] && t[TAG_BITS-1 -: PID_W] == cur_pid
          && t[2 +: HIGH_W] == lk_high) begin
        lk_hit = 1'b1;
        lk_wr_ok = t[0];
        lk_real = page_mem[entry_at(lk_row, s)];
      end
    end
  end

  // Kernel mode maps pages one to one and never faults
  wire lk_tbf = lk_valid && !lk_kernel && !lk_hit;  // R23
  wire lk_wpf = lk_valid && !lk_kernel && lk_hit && lk_store && !lk_wr_ok;
  wire [PAGE_W-1:0] lk_out = lk_kernel ? lk_vpage : lk_real;

  // ****************************************************************
  // Translation buffer writes
  // ****************************************************************
  // Every selected set is written so a whole row clears at once
  always_ff @(posedge clk) begin
    if (ce) begin
      for (int s = 0; s < SETS; s++) begin
        if (tag_store && sel[s]) begin
          tag_mem[entry_at(ent_row, s)] <= tag_packed;  // R11
        end
        if (page_store && sel[s]) begin
          page_mem[entry_at(ent_row, s)] <= translation_data_holding_q;  // R15
        end
      end
    end
  end

  // ****************************************************************
  // Holding registers
  // ****************************************************************
  // Tag holding: CPU copy masks undefined bits away
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      translation_tag_holding_q <= TAG_RESET;
    end else if (ce && tag_from_cpu) begin
      translation_tag_holding_q <= cop_cpu_word & TAG_MASK;  // R6 R24
    end else if (ce && tag_fetch) begin
      translation_tag_holding_q <= tag_rd_word;  // R10
    end
  end

  // Page holding keeps only the real page half
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      translation_data_holding_q <= PAGE_RESET;
    end else if (ce && page_from_cpu) begin
      translation_data_holding_q <= cop_cpu_word[PAGE_LSB +: PAGE_W];  // R13
    end else if (ce && page_fetch) begin
      translation_data_holding_q <= page_rd;  // R14
    end
  end

  // Control word: plain store, nothing else happens on a load
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      peripheral_control_word_q <= CTL_RESET;
    end else if (ce && ctl_load) begin
      peripheral_control_word_q <= cop_cpu_word;  // R17
    end
  end

  // Previous register number, so set-control addresses the older pick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcreg_prev_q <= MCREG_RESET;
    end else if (ce && io_issue) begin
      mcreg_prev_q <= ctl_mcreg;  // R25
    end
  end

  // ****************************************************************
  // Answers to the CPU
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_word_q <= 32'h0000_0000;
      cpu_word_valid_q <= 1'b0;
      priv_fault_q <= 1'b0;
    end else if (ce) begin
      cpu_word_valid_q <= tag_to_cpu || page_to_cpu;
      priv_fault_q <= own && fault;  // R3
      if (tag_to_cpu) begin
        cpu_word_q <= translation_tag_holding_q;  // R6
      end else if (page_to_cpu) begin
        cpu_word_q <= {translation_data_holding_q, 16'h0000};  // R12 R24
      end
    end
  end

  // ****************************************************************
  // Memory controller requests
  // ****************************************************************
  // Fetched word (through normal translation) is the operation data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mc_req_q <= 1'b0;
      mc_kind_q <= IO_NONE;
      mc_word_q <= 32'h0000_0000;
      mc_reg_q <= MCREG_RESET;
    end else if (ce) begin
      mc_req_q <= start_ok || io_get;
      if (start_ok || io_get) begin
        mc_kind_q <= io_get ? IO_GETCTL : start_kind;
        mc_word_q <= io_get ? 32'h0000_0000 : cop_mem_word;  // R18 R23
        mc_reg_q <= mcreg_prev_q;  // R22
      end
    end
  end

  // ****************************************************************
  // Lookup results
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lk_done_q <= 1'b0;
      lk_page_q <= PAGE_RESET;
      lk_tb_fault_q <= 1'b0;
      lk_wp_fault_q <= 1'b0;
    end else if (ce) begin
      lk_done_q <= lk_valid;
      lk_tb_fault_q <= lk_tbf;  // R23
      lk_wp_fault_q <= lk_wpf;  // R5
      if (lk_valid) begin
        lk_page_q <= lk_out;  // R9
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_row_clear;
    ce && tag_store && sel == 4'hf;
  endsequence

  sequence s_same_row_fetch;
    ce && tag_fetch && $onehot(sel) && !tag_from_cpu
      && row == $past(row) && cur_pid == $past(cur_pid);
  endsequence

  AST_PRIV_FAULT: assert property ( // R3
    ce && own && user_mode && priv_op |=> priv_fault_q && !mc_req_q)
    else $error("privileged transfer in user mode did not fault");
  AST_FOREIGN_QUIET: assert property ( // R1
    ce && cop_valid && !own |=> !priv_fault_q && !cpu_word_valid_q
      && !mc_req_q)
    else $error("foreign register number drew an answer");
  AST_TAG_LOAD: assert property ( // R6
    ce && tag_from_cpu |=>
      translation_tag_holding_q == ($past(cop_cpu_word) & TAG_MASK))
    else $error("tag holding not loaded from cpu word");
  AST_TAG_RETURN: assert property ( // R6
    ce && tag_to_cpu |=> cpu_word_valid_q
      && cpu_word_q == $past(translation_tag_holding_q))
    else $error("tag holding not returned to cpu");

  AST_PAGE_RETURN: assert property ( // R12
    ce && page_to_cpu |=> cpu_word_q[15:0] == 16'h0000
      && cpu_word_q[31:16] == $past(translation_data_holding_q))
    else $error("page word returned with wrong layout");

  AST_ROW_CLEAR_FETCH: assert property ( // R11
    s_row_clear ##1 s_same_row_fetch |=>
      translation_tag_holding_q == $past(translation_tag_holding_q))
    else $error("tag stored to all sets not read back");

  AST_CTL_LOAD_QUIET: assert property ( // R17
    ce && ctl_load && !io_issue |=> !mc_req_q
      && mcreg_prev_q == $past(mcreg_prev_q))
    else $error("control word load had a side effect");

  AST_PREV_MCREG: assert property ( // R22
    ce && io_issue && (io_get || start_ok) |=> mc_req_q
      && mc_reg_q == $past(mcreg_prev_q)
      && mcreg_prev_q == $past(ctl_mcreg))
    else $error("controller register number not the previous one");

  AST_START_READ: assert property ( // R20
    ce && io_start && ctl_ops == 3'h2 |=> mc_kind_q == IO_READ
      && mc_word_q == $past(cop_mem_word))
    else $error("read start did not send fetched word");

  AST_KERNEL_LOOKUP: assert property ( // R23
    ce && lk_valid && lk_kernel |=> lk_done_q && !lk_tb_fault_q
      && !lk_wp_fault_q && lk_page_q == $past(lk_vpage))
    else $error("kernel lookup not identity or faulted");

endmodule

// [tb/mc_model.sv]
// Memory controller stand-in that logs what the block asks of it
module mc_model
  import coproc_translation_io_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Request from the block
  input wire logic mc_req_q,
  input wire logic [2:0] mc_kind_q,
  input wire logic [31:0] mc_word_q,
  input wire logic [MCREG_W-1:0] mc_reg_q,
  // Log of the latest request
  output logic [2:0] seen_kind,
  output logic [31:0] seen_word,
  output logic [MCREG_W-1:0] seen_reg,
  output logic [7:0] seen_count
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strobe stands one cycle, so take it at the edge that ends it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_count <= 8'h00;
      seen_kind <= 3'h0;
      seen_word <= 32'h0000_0000;
      seen_reg <= '0;
    end else if (mc_req_q) begin
      seen_count <= seen_count + 8'h01;
      seen_kind <= mc_kind_q;
      seen_word <= mc_word_q;
      seen_reg <= mc_reg_q;
    end
  end
endmodule

// [tb/coproc_translation_io_regs_tb.sv]
// Self-checking bench for the coprocessor translation and I/O block
module coproc_translation_io_regs_tb
  import coproc_translation_io_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk, nrst, ce, cop_valid, user_mode, lk_valid, lk_store;
  logic lk_kernel, cpu_word_valid_q, priv_fault_q, mc_req_q;
  logic lk_done_q, lk_tb_fault_q, lk_wp_fault_q;
  logic got_valid, got_fault, got_req;
  logic [1:0] cop_op;
  logic [5:0] cop_reg;
  logic [7:0] cur_pid, seen_count, n_req;
  logic [31:0] cop_cpu_word, cop_vaddr, cop_mem_word, cpu_word_q;
  logic [31:0] mc_word_q, lk_vaddr, got_word, seen_word;
  logic [MCREG_W-1:0] mc_reg_q, seen_reg;
  logic [15:0] lk_page_q;
  logic [2:0] seen_kind;
  io_kind_type mc_kind_q;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  // Tag words: pid 05, high page 0a5, valid, writable or not
  localparam logic [6:0] ROW = 7'h12;
  localparam logic [31:0] T1 = {8'h05, 9'h0a5, 13'h0000, 2'h3};
  localparam logic [31:0] T2 = {8'h05, 9'h0a5, 13'h0000, 2'h2};
  localparam logic [31:0] P1 = 32'h1234_0000;
  localparam logic [31:0] LKVA = {9'h0a5, ROW, 16'h0000};

  coproc_translation_io_regs #(.ROWS(128)) i_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .cop_valid(cop_valid),
    .cop_op(cop_op), .cop_reg(cop_reg), .user_mode(user_mode),
    .cop_cpu_word(cop_cpu_word), .cop_vaddr(cop_vaddr),
    .cop_mem_word(cop_mem_word), .cur_pid(cur_pid),
    .cpu_word_q(cpu_word_q), .cpu_word_valid_q(cpu_word_valid_q),
    .priv_fault_q(priv_fault_q), .mc_req_q(mc_req_q),
    .mc_kind_q(mc_kind_q), .mc_word_q(mc_word_q), .mc_reg_q(mc_reg_q),
    .lk_valid(lk_valid), .lk_vaddr(lk_vaddr), .lk_store(lk_store),
    .lk_kernel(lk_kernel), .lk_done_q(lk_done_q),
    .lk_page_q(lk_page_q), .lk_tb_fault_q(lk_tb_fault_q),
    .lk_wp_fault_q(lk_wp_fault_q));

  mc_model i_mc (
    .clk(clk), .nrst(nrst), .mc_req_q(mc_req_q), .mc_kind_q(mc_kind_q),
    .mc_word_q(mc_word_q), .mc_reg_q(mc_reg_q), .seen_kind(seen_kind),
    .seen_word(seen_word), .seen_reg(seen_reg),
    .seen_count(seen_count));

  // Free-running clock; hang guard well above the run of ~210 cycles
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("BAD run length expected under 5000 cycles");
      conclude();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  function automatic logic [31:0] va(input logic [3:0] s,
                                     input logic [6:0] r);
    return {5'h00, s, r, 16'h0000};
  endfunction

  // One transfer; pulses captured in the cycle they stand
  task automatic xfer(input logic [1:0] op, input logic [5:0] rn,
                      input logic [31:0] w, input logic [31:0] a);
    cop_valid = 1'b1;
    cop_op = op;
    cop_reg = rn;
    cop_cpu_word = w;
    cop_mem_word = w;
    cop_vaddr = a;
    @(negedge clk);
    got_word = cpu_word_q;
    got_valid = cpu_word_valid_q;
    got_fault = priv_fault_q;
    got_req = mc_req_q;
    cop_valid = 1'b0;
    @(negedge clk);
    @(negedge clk);
  endtask

  function automatic logic [31:0] pulses();
    return {29'h0000_0000, got_valid, got_fault, got_req};
  endfunction

  task automatic rd(input logic [5:0] rn, input logic [31:0] exp);
    xfer(OP_TO_CPU, rn, 32'h0000_0000, 32'h0000_0000);
    chk("read pulses", 32'h0000_0004, pulses());
    chk("read word", exp, got_word);
  endtask

  task automatic look(input logic st, input logic kern,
                      input logic [31:0] a, input logic [2:0] exp,
                      input logic [15:0] page);
    lk_valid = 1'b1;
    lk_vaddr = a;
    lk_store = st;
    lk_kernel = kern;
    @(negedge clk);
    chk("lookup flags", {29'h0000_0000, exp},
        {29'h0000_0000, lk_done_q, lk_tb_fault_q, lk_wp_fault_q});
    if (exp[1:0] == 2'h0) begin
      chk("lookup page", {16'h0000, page}, {16'h0000, lk_page_q});
    end
    lk_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic io(input logic [31:0] ctl, input logic [31:0] d,
                    input logic [2:0] k, input logic [3:0] rg);
    xfer(OP_FROM_CPU, REG_CTL, ctl, 32'h0000_0000);
    chk("control load pulses", 32'h0000_0000, pulses());
    xfer(OP_FROM_MEM, REG_CTL, d, 32'h0000_0000);
    n_req = n_req + 8'h01;
    chk("request count", {24'h00_0000, n_req}, {24'h00_0000, seen_count});
    chk("request kind", {29'h0000_0000, k}, {29'h0000_0000, seen_kind});
    chk("request word", d, seen_word);
    chk("request reg", {28'h000_0000, rg}, {28'h000_0000, seen_reg});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_holding();
    rd(REG_TAG, TAG_RESET);
    xfer(OP_FROM_CPU, REG_TAG, 32'hffff_ffff, 32'h0000_0000);
    rd(REG_TAG, 32'hffff_8003);
    xfer(OP_FROM_CPU, REG_PAGE, 32'hffff_ffff, 32'h0000_0000);
    rd(REG_PAGE, 32'hffff_0000);
    ce = 1'b0;
    xfer(OP_FROM_CPU, REG_TAG, 32'h0000_0000, 32'h0000_0000);
    ce = 1'b1;
    rd(REG_TAG, 32'hffff_8003);
    $display("test holding done");
  endtask

  task automatic test_entries();
    xfer(OP_FROM_CPU, REG_TAG, T1, 32'h0000_0000);
    // Store to all sets, then fetch one back in the very next cycle
    cop_valid = 1'b1;
    cop_op = OP_TO_MEM;
    cop_vaddr = va(4'hf, ROW);
    @(negedge clk);
    cop_op = OP_FROM_MEM;
    cop_vaddr = va(4'h2, ROW);
    @(negedge clk);
    rd(REG_TAG, T1);
    xfer(OP_FROM_CPU, REG_PAGE, P1, 32'h0000_0000);
    xfer(OP_TO_MEM, REG_PAGE, 32'h0000_0000, va(4'hf, ROW));
    xfer(OP_FROM_CPU, REG_TAG, T2, 32'h0000_0000);
    xfer(OP_TO_MEM, REG_TAG, 32'h0000_0000, va(4'h4, ROW));
    for (int s = 0; s < 4; s++) begin
      xfer(OP_FROM_CPU, REG_PAGE, 32'h0000_0000, 32'h0000_0000);
      xfer(OP_FROM_MEM, REG_TAG, 32'h0000_0000, va(4'(1 << s), ROW));
      rd(REG_TAG, (s == 2) ? T2 : T1);
      xfer(OP_FROM_MEM, REG_PAGE, 32'h0000_0000, va(4'(1 << s), ROW));
      rd(REG_PAGE, P1);
    end
    cur_pid = 8'h0c;
    xfer(OP_FROM_MEM, REG_TAG, 32'h0000_0000, va(4'h4, ROW ^ 7'h09));
    rd(REG_TAG, T2);
    cur_pid = 8'h05;
    $display("test entries done");
  endtask

  task automatic test_lookup();
    xfer(OP_TO_MEM, REG_TAG, 32'h0000_0000, va(4'hf, ROW));
    look(1'b1, 1'b0, LKVA, 3'h5, 16'h0000);
    look(1'b0, 1'b0, LKVA, 3'h4, 16'h1234);
    look(1'b0, 1'b0, LKVA ^ 32'h0080_0000, 3'h6, 16'h0000);
    look(1'b1, 1'b1, 32'hbeef_0000, 3'h4, 16'hbeef);
    xfer(OP_FROM_CPU, REG_TAG, T1, 32'h0000_0000);
    xfer(OP_TO_MEM, REG_TAG, 32'h0000_0000, va(4'hf, ROW));
    look(1'b1, 1'b0, LKVA, 3'h4, 16'h1234);
    $display("test lookup done");
  endtask

  task automatic test_priv();
    user_mode = 1'b1;
    for (int r = 56; r <= 58; r++) begin
      for (int o = 0; o < 3; o++) begin
        xfer(2'(o), 6'(r), 32'h0000_0000, va(4'hf, ROW));
        chk("user fault", 32'h0000_0002, pulses());
      end
    end
    xfer(OP_FROM_CPU, REG_PSW, 32'h0000_0000, 32'h0000_0000);
    chk("psw fault", 32'h0000_0002, pulses());
    xfer(OP_FROM_CPU, REG_LOCK, 32'h0000_0000, 32'h0000_0000);
    chk("lock fault", 32'h0000_0002, pulses());
    xfer(OP_FROM_CPU, 6'h37, 32'h0000_0000, 32'h0000_0000);
    chk("foreign reg", 32'h0000_0000, pulses());
    rd(REG_TAG, T1);
    user_mode = 1'b0;
    xfer(OP_TO_CPU, 6'h00, 32'h0000_0000, 32'h0000_0000);
    chk("foreign read", 32'h0000_0000, pulses());
    look(1'b1, 1'b0, LKVA, 3'h4, 16'h1234);
    $display("test privilege done");
  endtask

  task automatic test_io();
    io(32'h4000_0003, 32'h0000_1000, IO_READ, 4'h0);
    io(32'h2000_0005, 32'h0000_2000, IO_WRITE, 4'h3);
    io(32'h8000_0009, 32'h0000_3000, IO_SETCTL, 4'h5);
    xfer(OP_TO_MEM, REG_CTL, 32'h0000_0000, 32'h0000_0000);
    n_req = n_req + 8'h01;
    chk("getctl kind", {29'h0000_0000, IO_GETCTL},
        {29'h0000_0000, seen_kind});
    chk("getctl reg", 32'h0000_0009, {28'h000_0000, seen_reg});
    xfer(OP_TO_CPU, REG_CTL, 32'h0000_0000, 32'h0000_0000);
    chk("control read", 32'h0000_0000, pulses());
    xfer(OP_FROM_CPU, REG_CTL, 32'h6000_0000, 32'h0000_0000);
    xfer(OP_FROM_MEM, REG_CTL, 32'h0000_4000, 32'h0000_0000);
    chk("two selects", {24'h00_0000, n_req}, {24'h00_0000, seen_count});
    $display("test io done");
  endtask

  // Reset, then every scenario in turn
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    cop_valid = 1'b0;
    cop_op = 2'h0;
    cop_reg = 6'h00;
    user_mode = 1'b0;
    cop_cpu_word = 32'h0000_0000;
    cop_vaddr = 32'h0000_0000;
    cop_mem_word = 32'h0000_0000;
    cur_pid = 8'h05;
    lk_valid = 1'b0;
    lk_vaddr = 32'h0000_0000;
    lk_store = 1'b0;
    lk_kernel = 1'b0;
    n_req = 8'h00;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    test_holding();
    test_entries();
    test_lookup();
    test_priv();
    test_io();
    conclude();
  end
endmodule
